// ===== core/ltsq_pkg.sv
package ltsq_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ = 20;
	localparam int ACK_WAIT_NS = 2000;
	localparam int ACK_WAIT_CYC = (ACK_WAIT_NS * CLK_MHZ + 999) / 1000;
	localparam int ACK_CNT_W = 8;

	// ************************************************************
	// frame limits
	// ************************************************************
	localparam logic [10:0] MAX_LEN_SMALL = 11'h5EA;
	localparam logic [10:0] MAX_LEN_HCAP = 11'h640;
	localparam logic [10:0] VLAN_TAG_LEN = 11'h004;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RETRY = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_CNT_BASE = 8'h40;
	localparam int CTRL_CLR_BIT = 0;
	localparam int CTRL_BASE_BIT = 1;
	localparam int CTRL_HCAP_BIT = 2;
	localparam int RETRY_W = 4;
	localparam logic [RETRY_W-1:0] RETRY_RST = 4'h7;
	localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
	localparam logic [31:0] CNT_ONE = 32'h0000_0001;

	// ************************************************************
	// queues
	// ************************************************************
	localparam int NQ = 3;
	localparam int QDEPTH = 4;
	localparam int QPTR_W = 2;
	localparam int QCNT_W = 3;
	localparam logic [QCNT_W-1:0] QCNT_FULL = 3'h4;

	// ************************************************************
	// counter indices
	// ************************************************************
	localparam int C_ETH_RX = 0;
	localparam int C_ETH_TX = 1;
	localparam int C_WTX_TOT = 2;
	localparam int C_WTX_BCN = 3;
	localparam int C_WTX_OTH = 4;
	localparam int C_SUB_TOT = 5;
	localparam int C_SUB_HI = 6;
	localparam int C_SUB_MID = 7;
	localparam int C_SUB_LO = 8;
	localparam int C_DROP = 9;
	localparam int C_RETX = 10;
	localparam int C_TXC_TOT = 11;
	localparam int C_TXC_1 = 12;
	localparam int C_TXC_2 = 13;
	localparam int C_TXC_M = 14;
	localparam int C_TXE_TOT = 15;
	localparam int C_TXE_DROP = 16;
	localparam int C_TXE_UND = 17;
	localparam int C_TXE_OTH = 18;
	localparam int C_WRX_TOT = 19;
	localparam int C_WRX_DATA = 20;
	localparam int C_RXE_TOT = 21;
	localparam int C_RXE_PHY = 22;
	localparam int C_RXE_CRC = 23;
	localparam int C_RXE_OVR = 24;
	localparam int C_RXE_DEC = 25;
	localparam int C_RXE_OTH = 26;
	localparam int C_RXC_TOT = 27;
	localparam int C_RXC_1 = 28;
	localparam int C_RXC_2 = 29;
	localparam int C_RXC_M = 30;
	localparam int C_BAD_FRAG = 31;
	localparam int C_DUP = 32;
	localparam int C_RATE_DROP = 33;
	localparam int NCNT = 34;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {PRIO_HIGH, PRIO_MED, PRIO_LOW} ltsq_prio_e;
	typedef enum logic [1:0] {KIND_DATA, KIND_CTRL, KIND_MGMT} ltsq_kind_e;
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT} ltsq_txst_e;

	typedef struct packed {
		logic [7:0] tag;
		logic [10:0] len;
		logic vlan;
		logic mgmt;
		logic beacon;
		logic bcast;
		logic needs_ack;
		logic [1:0] agg;
	} ltsq_desc_s;

	typedef struct packed {
		ltsq_desc_s desc;
		logic err;
		logic filtered;
		logic rate_drop;
		logic to_unit;
		logic prio_high;
	} ltsq_eth_rx_s;

	typedef struct packed {
		ltsq_desc_s desc;
		ltsq_kind_e kind;
		logic [11:0] seq;
		logic retry;
		logic phy_err;
		logic crc_err;
		logic overrun;
		logic decrypt_err;
		logic other_err;
		logic frag;
	} ltsq_wl_rx_s;

endpackage

// ===== core/ltsq_top.sv
`timescale 1ns/100ps
// Operation
// - Software clear command sets every Ethernet and wireless counter to zero, or to one if it counts an event in the clear cycle.
// - Frames rejected by the address filter touch no Ethernet counter.
// - Small variant: at most 1514 bytes, VLAN tag and CRC excluded.
// - High-capacity variant: up to 1600 bytes, VLAN included, CRC excluded.
// - Ethernet receive total counts every frame that passes the address filter, errored or not.
// - Wait for ACK, resend on timeout, discard at retry limit.
// - Each wireless-bound frame enters exactly one of three queues.
// - Strict priority: medium only if high empty, low if both empty.
// - Ordinary data goes high or low per its pre-rate-limit queue.
// - Base unit only: broadcast and multicast go to the medium queue.
// - Self-generated control and management frames go to the high queue.
// - Frames addressed to another bridge unit itself go high always.
// - Wireless tx total counts first successes; base unit splits beacons/others.
// - Count submitted data frames, total and per queue.
// - Retry-exhausted drop counter counts every discarded frame of any kind.
// - Retransmission counter counts every unsuccessful attempt.
// - Count tx and rx concatenated frames: single, double, more.
// - Tx event total with drop, underrun and other sub-counts.
// - Wireless rx total excludes errored and duplicate frames.
// - Received data counter includes duplicates.
// - Rx event total with phy, CRC, overrun, decrypt, other sub-counts.
// - Forward only the first copy of a duplicate; count discarded copies.
module ltsq_top
	import ltsq_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// ethernet receive side
	input wire logic eth_rx_valid,
	input wire ltsq_eth_rx_s eth_rx,
	output logic eth_rx_ready,
	// self-generated control and management frames
	input wire logic mgmt_valid,
	input wire ltsq_desc_s mgmt_desc,
	output logic mgmt_ready,
	// wireless transmit side
	output logic wl_tx_start,
	output ltsq_desc_s wl_tx_desc,
	input wire logic wl_ack,
	input wire logic wl_underrun,
	input wire logic wl_tx_other,
	// wireless receive side
	input wire logic wl_rx_valid,
	input wire ltsq_wl_rx_s wl_rx,
	// ethernet transmit side
	input wire logic unit_eth_tx,
	output logic eth_tx_valid,
	output ltsq_desc_s eth_tx_desc
);

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic len_ok(input ltsq_desc_s d, input logic hcap);
		logic [10:0] body;
		body = d.vlan ? d.len - VLAN_TAG_LEN : d.len;
		if (hcap)
			return d.len <= MAX_LEN_HCAP;
		return body <= MAX_LEN_SMALL;
	endfunction

	function automatic logic [3:0] agg_hits(input logic [1:0] agg);
		// bit0 total, bit1 single, bit2 double, bit3 more
		return {agg == 2'h3, agg == 2'h2, agg == 2'h1, agg != 2'h0};
	endfunction

	// ************************************************************
	// control registers
	// ************************************************************
	logic clr_cmd;
	logic base_unit;
	logic high_cap;
	logic [RETRY_W-1:0] hw_retry_limit;
	logic [31:0] cnt [NCNT];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			base_unit <= 1'b0;
			high_cap <= 1'b0;
			hw_retry_limit <= RETRY_RST;
			clr_cmd <= 1'b0;
		end else begin
			clr_cmd <= reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_CLR_BIT];
			if (reg_wr && reg_addr == REG_CTRL) begin
				base_unit <= reg_wdata[CTRL_BASE_BIT];
				high_cap <= reg_wdata[CTRL_HCAP_BIT];
			end
			if (reg_wr && reg_addr == REG_RETRY)
				hw_retry_limit <= reg_wdata[RETRY_W-1:0];
		end
	end

	// ************************************************************
	// queues
	// ************************************************************
	ltsq_desc_s qmem [NQ][QDEPTH];
	logic [QPTR_W-1:0] qwr [NQ];
	logic [QPTR_W-1:0] qrd [NQ];
	logic [QCNT_W-1:0] qcnt [NQ];
	logic push;
	ltsq_prio_e push_q;
	ltsq_desc_s push_desc;
	logic pop;
	ltsq_prio_e pop_q;
	logic eth_take;
	logic eth_acc;
	ltsq_prio_e eth_q;

	assign mgmt_ready = qcnt[PRIO_HIGH] != QCNT_FULL;
	assign eth_rx_ready = !mgmt_valid && qcnt[eth_q] != QCNT_FULL;
	assign eth_take = eth_rx_valid && eth_rx_ready;
	assign eth_acc = eth_take && !eth_rx.filtered && !eth_rx.err && !eth_rx.rate_drop
		&& len_ok(eth_rx.desc, high_cap);

	always_comb begin
		if (eth_rx.to_unit)
			eth_q = PRIO_HIGH;
		else if (eth_rx.desc.bcast && base_unit)
			eth_q = PRIO_MED;
		else
			eth_q = eth_rx.prio_high ? PRIO_HIGH : PRIO_LOW;
	end

	assign push = (mgmt_valid && mgmt_ready) || eth_acc;
	assign push_q = (mgmt_valid && mgmt_ready) ? PRIO_HIGH : eth_q;
	assign push_desc = (mgmt_valid && mgmt_ready) ? mgmt_desc : eth_rx.desc;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NQ; i++) begin
				qwr[i] <= '0;
				qrd[i] <= '0;
				qcnt[i] <= '0;
			end
		end else begin
			for (int i = 0; i < NQ; i++) begin
				if (push && int'(push_q) == i)
					qwr[i] <= qwr[i] + 1'b1;
				if (pop && int'(pop_q) == i)
					qrd[i] <= qrd[i] + 1'b1;
				qcnt[i] <= qcnt[i] + QCNT_W'(push && int'(push_q) == i)
					- QCNT_W'(pop && int'(pop_q) == i);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (push)
			qmem[push_q][qwr[push_q]] <= push_desc;
	end

	// ************************************************************
	// transmit scheduler and retry
	// ************************************************************
	ltsq_txst_e tx_st;
	logic [RETRY_W-1:0] tries;
	logic [ACK_CNT_W-1:0] ack_timer;
	logic tx_fail;
	logic tx_ok;
	logic tx_drop;

	always_comb begin
		pop_q = PRIO_HIGH;
		if (qcnt[PRIO_HIGH] == '0)
			pop_q = (qcnt[PRIO_MED] != '0) ? PRIO_MED : PRIO_LOW;
	end
	assign pop = tx_st == TX_IDLE && qcnt[pop_q] != '0;

	assign tx_fail = tx_st == TX_WAIT && wl_tx_desc.needs_ack && !wl_ack
		&& (wl_underrun || ack_timer == ACK_CNT_W'(ACK_WAIT_CYC - 1));
	assign tx_ok = tx_st == TX_WAIT && (!wl_tx_desc.needs_ack || wl_ack);
	assign tx_drop = tx_fail && tries == hw_retry_limit;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tx_st <= TX_IDLE;
			tries <= '0;
			ack_timer <= '0;
			wl_tx_start <= 1'b0;
			wl_tx_desc <= '0;
		end else begin
			wl_tx_start <= 1'b0;
			case (tx_st)
				TX_IDLE: begin
					if (pop) begin
						wl_tx_desc <= qmem[pop_q][qrd[pop_q]];
						wl_tx_start <= 1'b1;
						tries <= '0;
						ack_timer <= '0;
						tx_st <= TX_WAIT;
					end
				end
				TX_WAIT: begin
					ack_timer <= ack_timer + 1'b1;
					if (tx_ok || tx_drop) begin
						tx_st <= TX_IDLE;
					end else if (tx_fail) begin
						tries <= tries + 1'b1;
						ack_timer <= '0;
						wl_tx_start <= 1'b1;
					end
				end
				default: tx_st <= TX_IDLE;
			endcase
		end
	end

	// ************************************************************
	// wireless receive and duplicate filter
	// ************************************************************
	logic rx_bad;
	logic rx_dup;
	logic rx_data;
	logic [11:0] last_seq;
	logic last_seq_ok;

	assign rx_bad = wl_rx.phy_err || wl_rx.crc_err || wl_rx.overrun || wl_rx.decrypt_err
		|| wl_rx.other_err;
	assign rx_data = wl_rx_valid && !rx_bad && wl_rx.kind == KIND_DATA;
	assign rx_dup = rx_data && wl_rx.retry && last_seq_ok && wl_rx.seq == last_seq;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			last_seq <= '0;
			last_seq_ok <= 1'b0;
		end else if (rx_data) begin
			last_seq <= wl_rx.seq;
			last_seq_ok <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			eth_tx_valid <= 1'b0;
			eth_tx_desc <= '0;
		end else begin
			eth_tx_valid <= rx_data && !rx_dup && len_ok(wl_rx.desc, high_cap);
			if (rx_data)
				eth_tx_desc <= wl_rx.desc;
		end
	end

	// ************************************************************
	// counters
	// ************************************************************
	logic [NCNT-1:0] inc;
	logic [3:0] txc;
	logic [3:0] rxc;
	logic tx_first_ok;

	assign txc = agg_hits(wl_tx_desc.agg);
	assign rxc = agg_hits(wl_rx.desc.agg);
	assign tx_first_ok = tx_ok && tries == '0;

	always_comb begin
		inc = '0;
		inc[C_ETH_RX] = eth_take && !eth_rx.filtered;
		inc[C_RATE_DROP] = eth_take && !eth_rx.filtered && eth_rx.rate_drop;
		inc[C_ETH_TX] = eth_tx_valid || unit_eth_tx;
		inc[C_WTX_TOT] = tx_first_ok;
		inc[C_WTX_BCN] = tx_first_ok && base_unit && wl_tx_desc.beacon;
		inc[C_WTX_OTH] = tx_first_ok && base_unit && !wl_tx_desc.beacon;
		inc[C_SUB_TOT] = eth_acc && !(mgmt_valid && mgmt_ready);
		inc[C_SUB_HI] = inc[C_SUB_TOT] && eth_q == PRIO_HIGH;
		inc[C_SUB_MID] = inc[C_SUB_TOT] && eth_q == PRIO_MED;
		inc[C_SUB_LO] = inc[C_SUB_TOT] && eth_q == PRIO_LOW;
		inc[C_DROP] = tx_drop;
		inc[C_RETX] = tx_fail;
		inc[C_TXC_TOT] = tx_first_ok && txc[0];
		inc[C_TXC_1] = tx_first_ok && txc[1];
		inc[C_TXC_2] = tx_first_ok && txc[2];
		inc[C_TXC_M] = tx_first_ok && txc[3];
		inc[C_TXE_DROP] = tx_drop;
		inc[C_TXE_UND] = tx_st == TX_WAIT && wl_underrun;
		inc[C_TXE_OTH] = wl_tx_other;
		inc[C_TXE_TOT] = inc[C_TXE_DROP] || inc[C_TXE_UND] || inc[C_TXE_OTH];
		inc[C_WRX_TOT] = wl_rx_valid && !rx_bad && !rx_dup;
		inc[C_WRX_DATA] = rx_data;
		inc[C_RXE_TOT] = wl_rx_valid && rx_bad;
		inc[C_RXE_PHY] = wl_rx_valid && wl_rx.phy_err;
		inc[C_RXE_CRC] = wl_rx_valid && wl_rx.crc_err;
		inc[C_RXE_OVR] = wl_rx_valid && wl_rx.overrun;
		inc[C_RXE_DEC] = wl_rx_valid && wl_rx.decrypt_err;
		inc[C_RXE_OTH] = wl_rx_valid && wl_rx.other_err;
		inc[C_RXC_TOT] = wl_rx_valid && !rx_bad && rxc[0];
		inc[C_RXC_1] = wl_rx_valid && !rx_bad && rxc[1];
		inc[C_RXC_2] = wl_rx_valid && !rx_bad && rxc[2];
		inc[C_RXC_M] = wl_rx_valid && !rx_bad && rxc[3];
		inc[C_BAD_FRAG] = wl_rx_valid && wl_rx.crc_err && wl_rx.frag;
		inc[C_DUP] = rx_dup;
	end

	// clear, event in same cycle kept
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NCNT; i++)
				cnt[i] <= CNT_ZERO;
		end else begin
			for (int i = 0; i < NCNT; i++) begin
				if (clr_cmd)
					cnt[i] <= inc[i] ? CNT_ONE : CNT_ZERO;
				else if (inc[i])
					cnt[i] <= cnt[i] + CNT_ONE;
			end
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	logic [7:0] cnt_off;
	logic [5:0] cnt_idx;

	assign cnt_off = reg_addr - REG_CNT_BASE;
	assign cnt_idx = cnt_off[7:2];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_rd) begin
				if (reg_addr == REG_CTRL)
					reg_rdata <= 32'({high_cap, base_unit, 1'b0});
				else if (reg_addr == REG_RETRY)
					reg_rdata <= 32'(hw_retry_limit);
				else if (reg_addr == REG_STATUS)
					reg_rdata <= 32'({tx_st == TX_WAIT, qcnt[PRIO_LOW], qcnt[PRIO_MED],
						qcnt[PRIO_HIGH]});
				else if (reg_addr >= REG_CNT_BASE && cnt_off[1:0] == 2'h0
					&& int'(cnt_idx) < NCNT)
					reg_rdata <= cnt[cnt_idx];
			end
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	AST_CLEAR: assert property (@(posedge core_clk) disable iff (!resetn)
		clr_cmd && !inc[C_ETH_RX] |=> cnt[C_ETH_RX] == CNT_ZERO)
		else $error("counter not cleared");
	AST_FILTER: assert property (@(posedge core_clk) disable iff (!resetn)
		eth_take && eth_rx.filtered && !clr_cmd |=> cnt[C_ETH_RX] == $past(cnt[C_ETH_RX]))
		else $error("filtered frame counted");
	AST_ETH_RX: assert property (@(posedge core_clk) disable iff (!resetn)
		eth_take && !eth_rx.filtered && !clr_cmd
		|=> cnt[C_ETH_RX] == $past(cnt[C_ETH_RX]) + CNT_ONE)
		else $error("eth rx total missed");
	AST_DROP: assert property (@(posedge core_clk) disable iff (!resetn)
		tx_fail && tries == hw_retry_limit |=> tx_st == TX_IDLE && !wl_tx_start)
		else $error("frame not dropped at limit");
	AST_RESEND: assert property (@(posedge core_clk) disable iff (!resetn)
		tx_fail && tries != hw_retry_limit |=> wl_tx_start && tx_st == TX_WAIT)
		else $error("no resend");
	AST_PRIO: assert property (@(posedge core_clk) disable iff (!resetn)
		pop && pop_q != PRIO_HIGH |-> qcnt[PRIO_HIGH] == '0
		&& (pop_q == PRIO_MED || qcnt[PRIO_MED] == '0))
		else $error("priority violated");
	AST_UNIT_HIGH: assert property (@(posedge core_clk) disable iff (!resetn)
		eth_rx.to_unit |-> eth_q == PRIO_HIGH)
		else $error("unit frame not high");
	AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (!resetn)
		wl_tx_start && wl_tx_desc.needs_ack ##1 (!wl_ack && !wl_underrun)[*3] |-> !wl_tx_start)
		else $error("early resend");
	AST_DUP: assert property (@(posedge core_clk) disable iff (!resetn)
		rx_dup |=> !eth_tx_valid)
		else $error("duplicate forwarded");
	AST_TXEV: assert property (@(posedge core_clk) disable iff (!resetn)
		tx_drop && !clr_cmd |=> cnt[C_TXE_TOT] == $past(cnt[C_TXE_TOT]) + CNT_ONE)
		else $error("tx event total missed");

endmodule

// ===== verif/ltsq_medium_model.sv
`timescale 1ns/100ps
module ltsq_medium_model
	import ltsq_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// transmit side of the unit
	input wire logic wl_tx_start,
	input wire ltsq_desc_s wl_tx_desc,
	// behaviour chosen by the bench
	input wire logic arm,
	input wire logic [3:0] n_bad,
	input wire logic und,
	input wire logic [5:0] ack_dly,
	// answers from the medium
	output logic wl_ack,
	output logic wl_underrun
);
	// ************************************************************
	// attempt tracking
	// ************************************************************
	logic [3:0] seen;
	logic [5:0] cnt;
	logic act;
	logic bad;

	// first n_bad attempts after arm fail, silently or by underrun
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			seen <= 4'h0;
			cnt <= 6'h00;
			act <= 1'b0;
			bad <= 1'b0;
			wl_ack <= 1'b0;
			wl_underrun <= 1'b0;
		end else begin
			wl_ack <= 1'b0;
			wl_underrun <= 1'b0;
			if (arm) begin
				seen <= 4'h0;
			end else if (wl_tx_start && wl_tx_desc.needs_ack) begin
				seen <= seen + 4'h1;
				act <= 1'b1;
				bad <= (seen < n_bad);
				cnt <= und ? 6'h02 : ack_dly;
			end else if (act) begin
				cnt <= cnt - 6'h01;
				if (cnt == 6'h01) begin
					act <= 1'b0;
					wl_ack <= !bad;
					wl_underrun <= bad && und;
				end
			end
		end
	end
endmodule

// ===== verif/ltsq_top_bench.sv
`timescale 1ns/100ps
module ltsq_top_bench;
	import ltsq_pkg::*;
	// ************************************************************
	// signals
	// ************************************************************
	localparam logic [6:0] F_VLAN = 7'h40, F_BC = 7'h20, F_ERR = 7'h10, F_FLT = 7'h08;
	localparam logic [6:0] F_RD = 7'h04, F_UNIT = 7'h02, F_HI = 7'h01;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic eth_rx_valid = 1'b0;
	ltsq_eth_rx_s eth_rx = '0;
	logic eth_rx_ready;
	logic mgmt_valid = 1'b0;
	ltsq_desc_s mgmt_desc = '0;
	logic mgmt_ready;
	logic wl_tx_start;
	ltsq_desc_s wl_tx_desc;
	logic wl_ack;
	logic wl_underrun;
	logic wl_rx_valid = 1'b0;
	ltsq_wl_rx_s wl_rx = '0;
	logic unit_eth_tx = 1'b0;
	logic wl_tx_other = 1'b0;
	logic eth_tx_valid;
	ltsq_desc_s eth_tx_desc;
	logic arm = 1'b0;
	logic [3:0] n_bad = 4'h0;
	logic und = 1'b0;
	logic [5:0] ack_dly = 6'h03;
	logic [31:0] expc [NCNT];
	logic [31:0] rd;
	logic [7:0] txq [$];
	int n_fail = 0;
	int n_checks = 0;
	int n_fwd = 0;
	logic [7:0] fwd_tag = 8'h00;

	ltsq_top i_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.eth_rx_valid, .eth_rx, .eth_rx_ready, .mgmt_valid, .mgmt_desc, .mgmt_ready,
		.wl_tx_start, .wl_tx_desc, .wl_ack, .wl_underrun, .wl_tx_other,
		.wl_rx_valid, .wl_rx, .unit_eth_tx, .eth_tx_valid, .eth_tx_desc);
	ltsq_medium_model i_med (.core_clk, .resetn, .wl_tx_start, .wl_tx_desc, .arm, .n_bad,
		.und, .ack_dly, .wl_ack, .wl_underrun);

	initial forever #25 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		if (wl_tx_start === 1'b1)
			txq.push_back(wl_tx_desc.tag);
		if (eth_tx_valid === 1'b1) begin
			n_fwd++;
			fwd_tag = eth_tx_desc.tag;
		end
	end

	// ************************************************************
	// tasks
	// ************************************************************
	task automatic end_sim;
		if (n_fail == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic bound(input int k, input int m);
		if (k >= m) begin
			cmp("wait_bound", CNT_ZERO, CNT_ONE);
			end_sim();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		rdr(a, rd);
		cmp(nm, e, rd);
	endtask
	task automatic chk_all;
		for (int i = 0; i < NCNT; i++)
			chk(REG_CNT_BASE + 8'(4 * i), expc[i], $sformatf("cnt%0d", i));
	endtask
	function automatic void inc(input int q[$]);
		foreach (q[i])
			expc[q[i]] = expc[q[i]] + CNT_ONE;
	endfunction
	function automatic ltsq_eth_rx_s ef(input logic [7:0] t, input logic [10:0] n,
		input logic [6:0] f);
		ef = '0;
		ef.desc.tag = t;
		ef.desc.len = n;
		ef.desc.needs_ack = 1'b1;
		{ef.desc.vlan, ef.desc.bcast, ef.err, ef.filtered, ef.rate_drop, ef.to_unit,
			ef.prio_high} = f;
	endfunction
	task automatic send(input logic m, input ltsq_eth_rx_s f);
		int k;
		k = 0;
		@(posedge core_clk);
		if (m) begin
			mgmt_valid <= 1'b1;
			mgmt_desc <= f.desc;
		end else begin
			eth_rx_valid <= 1'b1;
			eth_rx <= f;
		end
		do begin
			@(negedge core_clk);
			k++;
		end while ((m ? mgmt_ready : eth_rx_ready) !== 1'b1 && k < 200);
		bound(k, 200);
		@(posedge core_clk);
		mgmt_valid <= 1'b0;
		eth_rx_valid <= 1'b0;
		mgmt_desc <= ~f.desc;
		eth_rx <= ~f;
	endtask
	task automatic wrx(input ltsq_kind_e kd, input logic [11:0] s, input logic r,
		input logic [4:0] e);
		ltsq_wl_rx_s w;
		w = '0;
		w.desc.len = 11'h040;
		w.kind = kd;
		w.seq = s;
		w.retry = r;
		w.desc.tag = s[7:0];
		w.desc.agg = s[1:0];
		w.frag = 1'b1;
		{w.phy_err, w.crc_err, w.overrun, w.decrypt_err, w.other_err} = e;
		@(posedge core_clk);
		wl_rx_valid <= 1'b1;
		wl_rx <= w;
		@(posedge core_clk);
		wl_rx_valid <= 1'b0;
		wl_rx <= ~w;
	endtask
	task automatic idle;
		int k;
		int n;
		k = 0;
		n = 0;
		do begin
			rdr(REG_STATUS, rd);
			n = (rd[9:0] === 10'h000) ? n + 1 : 0;
			k++;
		end while (n < 2 && k < 300);
		bound(k, 300);
	endtask
	task automatic ckq(input logic [7:0] e[$]);
		cmp("tx_count", 32'(e.size()), 32'(txq.size()));
		foreach (e[i])
			if (i < txq.size())
				cmp("tx_tag", {24'h00_0000, e[i]}, {24'h00_0000, txq[i]});
		txq.delete();
	endtask
	task automatic rearm;
		arm <= 1'b1;
		@(posedge core_clk);
		arm <= 1'b0;
	endtask

	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		repeat (100000) @(posedge core_clk);
		cmp("watchdog", CNT_ZERO, CNT_ONE);
		end_sim();
	end
	initial begin
		ltsq_eth_rx_s m;
		foreach (expc[i])
			expc[i] = CNT_ZERO;
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		chk(REG_RETRY, {28'h000_0000, RETRY_RST}, "retry_rst");
		chk(8'h30, CNT_ZERO, "unmapped");
		chk_all();
		send(1'b0, ef(8'h01, 11'h064, F_FLT));
		send(1'b0, ef(8'h02, 11'h064, F_ERR));
		send(1'b0, ef(8'h03, 11'h064, F_RD));
		send(1'b0, ef(8'h04, 11'h5EB, 7'h00));
		send(1'b0, ef(8'h05, 11'h5EE, F_VLAN));
		send(1'b0, ef(8'h06, MAX_LEN_SMALL, F_HI));
		idle();
		inc('{C_ETH_RX, C_ETH_RX, C_ETH_RX, C_ETH_RX, C_ETH_RX, C_RATE_DROP, C_SUB_TOT});
		inc('{C_SUB_TOT, C_SUB_LO, C_SUB_HI, C_WTX_TOT, C_WTX_TOT});
		ckq('{8'h05, 8'h06});
		wr(REG_CTRL, 32'h0000_0004);
		send(1'b0, ef(8'h07, MAX_LEN_HCAP, F_VLAN));
		send(1'b0, ef(8'h08, 11'h641, 7'h00));
		idle();
		inc('{C_ETH_RX, C_ETH_RX, C_SUB_TOT, C_SUB_LO, C_WTX_TOT});
		ckq('{8'h07});
		chk_all();
		// slow acks so that frames wait in all three queues behind the first frame
		wr(REG_CTRL, 32'h0000_0002);
		ack_dly <= 6'h1E;
		m = ef(8'h14, 11'h040, 7'h00);
		m.desc.beacon = 1'b1;
		m.desc.needs_ack = 1'b0;
		m.desc.agg = 2'h2;
		send(1'b0, ef(8'h10, 11'h040, 7'h00));
		send(1'b0, ef(8'h11, 11'h040, 7'h00));
		send(1'b0, ef(8'h12, 11'h040, F_BC));
		send(1'b0, ef(8'h13, 11'h040, F_UNIT));
		send(1'b1, m);
		idle();
		inc('{C_ETH_RX, C_ETH_RX, C_ETH_RX, C_ETH_RX, C_SUB_TOT, C_SUB_TOT, C_SUB_TOT});
		inc('{C_SUB_TOT, C_SUB_LO, C_SUB_LO, C_SUB_MID, C_SUB_HI, C_WTX_BCN});
		inc('{C_WTX_TOT, C_WTX_TOT, C_WTX_TOT, C_WTX_TOT, C_WTX_TOT});
		inc('{C_WTX_OTH, C_WTX_OTH, C_WTX_OTH, C_WTX_OTH});
		inc('{C_TXC_TOT, C_TXC_2});
		ckq('{8'h10, 8'h13, 8'h14, 8'h12, 8'h11});
		chk_all();
		wr(REG_CTRL, 32'h0000_0000);
		ack_dly <= 6'h03;
		wr(REG_RETRY, 32'h0000_0002);
		n_bad <= 4'hF;
		rearm();
		send(1'b0, ef(8'h20, 11'h040, F_HI));
		idle();
		inc('{C_ETH_RX, C_SUB_TOT, C_SUB_HI, C_RETX, C_RETX, C_RETX, C_DROP});
		inc('{C_TXE_DROP, C_TXE_TOT});
		ckq('{8'h20, 8'h20, 8'h20});
		wr(REG_RETRY, 32'h0000_0000);
		und <= 1'b1;
		rearm();
		send(1'b0, ef(8'h21, 11'h040, F_HI));
		idle();
		inc('{C_ETH_RX, C_SUB_TOT, C_SUB_HI, C_RETX, C_DROP, C_TXE_DROP, C_TXE_UND});
		inc('{C_TXE_TOT});
		ckq('{8'h21});
		und <= 1'b0;
		n_bad <= 4'h0;
		chk_all();
		wrx(KIND_DATA, 12'h005, 1'b0, 5'h00);
		wrx(KIND_DATA, 12'h005, 1'b1, 5'h00);
		wrx(KIND_DATA, 12'h006, 1'b1, 5'h00);
		wrx(KIND_MGMT, 12'h007, 1'b0, 5'h00);
		for (int i = 0; i < 5; i++) begin
			wrx(KIND_CTRL, 12'h008, 1'b0, 5'(5'h01 << i));
			inc('{C_RXE_TOT, C_RXE_OTH - i});
		end
		unit_eth_tx <= 1'b1;
		wl_tx_other <= 1'b1;
		@(posedge core_clk);
		unit_eth_tx <= 1'b0;
		wl_tx_other <= 1'b0;
		repeat (2) @(posedge core_clk);
		inc('{C_ETH_TX, C_ETH_TX, C_ETH_TX, C_WRX_TOT, C_WRX_TOT, C_WRX_TOT, C_DUP});
		inc('{C_WRX_DATA, C_WRX_DATA, C_WRX_DATA});
		inc('{C_RXC_TOT, C_RXC_TOT, C_RXC_TOT, C_RXC_TOT, C_RXC_1, C_RXC_1, C_RXC_2});
		inc('{C_RXC_M, C_BAD_FRAG, C_TXE_OTH, C_TXE_TOT});
		cmp("fwd", 32'h0000_0002, 32'(n_fwd));
		cmp("fwd_tag", 32'h0000_0006, {24'h00_0000, fwd_tag});
		chk_all();
		wr(REG_CTRL, 32'h0000_0001);
		foreach (expc[i])
			expc[i] = CNT_ZERO;
		chk(REG_CTRL, CNT_ZERO, "ctrl_clr");
		chk_all();
		end_sim();
	end
endmodule
